// ===== pps_pkg.sv
// What this block does
// - vertical sync output comes from the vertical sync pin or the sync separator.
// - no override: vertical activity picks pin, else green activity picks separator, else manual bit.
// - pixel clock locks to horizontal pin or green sync slicer output.
// - pixel clock times sampling and all output data processing.
// - feedback divider is a 12 bit counter, usable ratio 17 to 4096.
// - divider held in two registers; effective ratio is programmed value plus one, values below 16 held at ratio 17.
// - effective ratio is the pixel periods per whole line, active plus blanking.
// - divider resets to 1693, effective ratio 1694.
// - top two bits of range register select oscillator range band.
// - bits 5:3 of range register select charge pump current, 50 to 1500 uA.
// - during coast the loop holds frequency and phase and ignores the reference.
// - when coast ends the loop resumes locking to the reference.
// - coast control bit 5 picks internal vertical sync or external coast pin.
// - separator is a low-pass filter rejecting changes shorter than 0-255 ticks, default 32.
// - status bit 4 reports vertical activity, bit 1 green sync activity; feed selector.
package pps_pkg;
  // clocking and timebase
  localparam int CLK_MHZ = 100;
  localparam int TB_MHZ = 5;
  localparam int TB_DIV_CYC = CLK_MHZ / TB_MHZ;
  localparam int ACT_WINDOW_US = 1000;
  localparam int ACT_WINDOW_CYC = ACT_WINDOW_US * CLK_MHZ;

  // register indices; byte address is four times the index
  localparam logic [5:0] REG_DIV_HIGH = 6'h01;
  localparam logic [5:0] REG_DIV_LOW = 6'h02;
  localparam logic [5:0] REG_RANGE_PUMP = 6'h03;
  localparam logic [5:0] REG_SYNC_CTRL = 6'h0e;
  localparam logic [5:0] REG_COAST_CTRL = 6'h0f;
  localparam logic [5:0] REG_SEP_TICKS = 6'h10;
  localparam logic [5:0] REG_STATUS = 6'h14;
  localparam logic [5:0] REG_IRQ_STAT = 6'h15;
  localparam logic [5:0] REG_IRQ_MASK = 6'h16;

  // field positions
  localparam int MAN_V_BIT = 0;
  localparam int OV_V_BIT = 1;
  localparam int MAN_H_BIT = 3;
  localparam int OV_H_BIT = 4;
  localparam int COAST_EXT_BIT = 5;
  localparam int STAT_GREEN_BIT = 1;
  localparam int STAT_VACT_BIT = 4;
  localparam int STAT_HACT_BIT = 7;
  localparam int RANGE_LSB = 6;
  localparam int PUMP_LSB = 3;
  localparam int DIV_LOW_LSB = 4;

  // pin order inside the synchroniser vector
  localparam int PIN_H = 0;
  localparam int PIN_V = 1;
  localparam int PIN_GREEN = 2;
  localparam int PIN_COAST = 3;

  // interrupt bits
  localparam int IRQ_HACT = 0;
  localparam int IRQ_VACT = 1;
  localparam int IRQ_GREEN = 2;
  localparam int IRQ_COAST = 3;

  // reset values
  localparam logic [7:0] DIV_HIGH_RST = 8'h69;
  localparam logic [7:0] DIV_LOW_RST = 8'hd0;
  localparam logic [7:0] RANGE_PUMP_RST = 8'h00;
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [7:0] COAST_CTRL_RST = 8'h00;
  localparam logic [7:0] SEP_TICKS_RST = 8'h20;
  localparam logic [11:0] DIV_MIN = 12'h010;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pps_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pps_wb_rsp_t;

  typedef struct packed {
    logic ref_sel;
    logic ref_pulse;
    logic coast;
    logic line_start;
    logic [12:0] ratio;
    logic [1:0] osc_range;
    logic [2:0] pump_sel;
    logic [10:0] pump_ua;
  } pps_pll_ctl_t;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] level;
    logic [2:0] seen;
    logic [2:0] active;
    logic [16:0] win;
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic [7:0] range_pump;
    logic [7:0] sync_ctrl;
    logic [7:0] coast_ctrl;
    logic [7:0] sep_ticks;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic ack;
    logic [7:0] rdata;
    logic hsel;
    logic vsel;
    logic vout;
    logic coast;
    logic ref_pulse;
    logic line;
    logic [11:0] pix;
  } pps_state_t;

  typedef struct packed {
    logic [4:0] tb;
    logic [7:0] run;
    logic out;
  } pps_sep_state_t;

  // charge pump current in uA for each selector code
  function automatic logic [10:0] pps_pump_ua(input logic [2:0] code);
    unique case (code)
      3'h0: pps_pump_ua = 11'h032;
      3'h1: pps_pump_ua = 11'h064;
      3'h2: pps_pump_ua = 11'h096;
      3'h3: pps_pump_ua = 11'h0fa;
      3'h4: pps_pump_ua = 11'h15e;
      3'h5: pps_pump_ua = 11'h1f4;
      3'h6: pps_pump_ua = 11'h2ee;
      3'h7: pps_pump_ua = 11'h5dc;
    endcase
  endfunction
endpackage

// ===== pps_sync_sep.sv
`timescale 1ns/1ns
`default_nettype none
module pps_sync_sep import pps_pkg::*; (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic csync_in,
  input wire logic [7:0] ticks_in,
  output logic vsync_sep_out
);
  pps_sep_state_t s;
  pps_sep_state_t next_s;
  logic tick;

  // timebase strobe, one cycle in every TB_DIV_CYC
  assign tick = (s.tb == 5'(TB_DIV_CYC - 1));
  assign vsync_sep_out = s.out;

  // a level change passes only after it has stood ticks_in ticks
  always_comb begin
    next_s = s;
    next_s.tb = tick ? 5'h00 : s.tb + 5'h01;
    if (csync_in == s.out) begin
      next_s.run = 8'h00; // glitch ended: restart the count
    end else if (tick) begin
      if (s.run >= ticks_in) begin
        next_s.out = csync_in;
        next_s.run = 8'h00;
      end else begin
        next_s.run = s.run + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  sequence sep_change_s;
    s.out != $past(s.out);
  endsequence

  sep_tick_only_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sep_change_s |-> $past(tick) && ($past(s.run) >= $past(ticks_in)))
    else $error("separator output moved off a tick or too early");

  sep_follow_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sep_change_s |-> s.out == $past(csync_in))
    else $error("separator output took a value the input did not have");
endmodule
`default_nettype wire

// ===== pps_top.sv
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pps_top import pps_pkg::*; #(
  parameter int ACT_WINDOW = ACT_WINDOW_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire pps_wb_req_t wb_in,
  output pps_wb_rsp_t wb_out,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic green_channel_sync_input_in,
  input wire logic coast_ext_in,
  output logic vertical_sync_output_out,
  output pps_pll_ctl_t pll_out,
  output logic irq_out
);
  pps_state_t s;
  pps_state_t next_s;
  logic [3:0] lvl_n;
  logic [3:0] pin_edge;
  logic sep_v;
  logic [11:0] div_prog;
  logic [11:0] div_val;
  logic [5:0] idx;
  logic wr;
  logic rd_new;
  logic [3:0] irq_ev;
  logic win_end;
  logic [2:0] act_n;
  logic coast_n;
  logic href_n;
  logic ref_edge;
  logic [7:0] status;

  // a pin level counts only once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      assign lvl_n[gi] = (s.sync2[gi] == s.sync3[gi]) ? s.sync3[gi] : s.level[gi];
      assign pin_edge[gi] = lvl_n[gi] != s.level[gi];
    end
  endgenerate

  // divider halves joined, short settings held at the least usable ratio
  assign div_prog = {s.div_high, s.div_low[7:DIV_LOW_LSB]};
  assign div_val = (div_prog < DIV_MIN) ? DIV_MIN : div_prog;

  assign idx = wb_in.adr[7:2];
  assign wr = wb_in.cyc && wb_in.stb && wb_in.we && s.ack && wb_in.sel[0];
  assign rd_new = wb_in.cyc && wb_in.stb && !s.ack;
  assign status = {s.active[0], 2'h0, s.active[1], 2'h0, s.active[2], 1'h0};

  // horizontal reference, rising edge of the chosen source
  assign href_n = s.hsel ? lvl_n[PIN_GREEN] : lvl_n[PIN_H];
  assign ref_edge = href_n && !(s.hsel ? s.level[PIN_GREEN] : s.level[PIN_H]);

  // composite sync into the separator follows the horizontal source choice
  pps_sync_sep u_sep (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .csync_in(s.hsel ? s.level[PIN_GREEN] : s.level[PIN_H]),
    .ticks_in(s.sep_ticks),
    .vsync_sep_out(sep_v)
  );

  // activity flags and coast as they stand after this edge, worked out from
  // the registered state so the event logic forms no loop through next_s
  assign win_end = (s.win == 17'(ACT_WINDOW - 1));
  assign act_n = win_end ? (s.seen | pin_edge[2:0]) : s.active;
  assign coast_n = s.coast_ctrl[COAST_EXT_BIT] ? s.level[PIN_COAST] : s.vout;

  // events: any activity change, and the start of coast
  assign irq_ev[IRQ_HACT] = act_n[0] != s.active[0];
  assign irq_ev[IRQ_VACT] = act_n[1] != s.active[1];
  assign irq_ev[IRQ_GREEN] = act_n[2] != s.active[2];
  assign irq_ev[IRQ_COAST] = coast_n && !s.coast;

  always_comb begin
    next_s = s;
    // pin synchronisers
    next_s.sync1 = {coast_ext_in, green_channel_sync_input_in, vsync_in, hsync_in};
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    next_s.level = lvl_n;

    // activity: a pin is active if it moved during the last window
    next_s.seen = s.seen | pin_edge[2:0];
    if (win_end) begin
      next_s.win = 17'h00000;
      next_s.active = act_n;
      next_s.seen = 3'h0;
    end else begin
      next_s.win = s.win + 17'h00001;
    end

    // horizontal source: override or both active lets the manual bit pick; otherwise green wins only when hsync is idle
    if (s.sync_ctrl[OV_H_BIT] || (s.active[0] && s.active[2])) begin
      next_s.hsel = s.sync_ctrl[MAN_H_BIT];
    end else begin
      next_s.hsel = !s.active[0] && s.active[2];
    end

    // vertical source selector
    if (s.sync_ctrl[OV_V_BIT]) begin
      next_s.vsel = s.sync_ctrl[MAN_V_BIT];
    end else if (s.active[1]) begin
      next_s.vsel = 1'b0;
    end else if (s.active[2]) begin
      next_s.vsel = 1'b1;
    end else begin
      next_s.vsel = s.sync_ctrl[MAN_V_BIT];
    end
    next_s.vout = s.vsel ? sep_v : s.level[PIN_V];

    // coast from the vertical output or the external pin
    next_s.coast = coast_n;

    // line counter on the pixel timebase; coast blocks resync
    next_s.ref_pulse = ref_edge && !s.coast;
    next_s.line = 1'b0;
    if (next_s.ref_pulse) begin
      next_s.pix = 12'h000;
    end else if (s.pix >= div_val) begin
      next_s.pix = 12'h000;
      next_s.line = 1'b1;
    end else begin
      next_s.pix = s.pix + 12'h001;
    end

    // bus: ack one cycle after the request, dropped the cycle after
    next_s.ack = rd_new;
    if (rd_new) begin
      unique case (idx)
        REG_DIV_HIGH: next_s.rdata = s.div_high;
        REG_DIV_LOW: next_s.rdata = s.div_low;
        REG_RANGE_PUMP: next_s.rdata = s.range_pump;
        REG_SYNC_CTRL: next_s.rdata = s.sync_ctrl;
        REG_COAST_CTRL: next_s.rdata = s.coast_ctrl;
        REG_SEP_TICKS: next_s.rdata = s.sep_ticks;
        REG_STATUS: next_s.rdata = status;
        REG_IRQ_STAT: next_s.rdata = {4'h0, s.irq_stat};
        REG_IRQ_MASK: next_s.rdata = {4'h0, s.irq_mask};
        default: next_s.rdata = 8'h00; // unmapped reads as zero
      endcase
    end
    if (wr) begin
      unique case (idx)
        REG_DIV_HIGH: next_s.div_high = wb_in.dat[7:0];
        REG_DIV_LOW: next_s.div_low = {wb_in.dat[7:DIV_LOW_LSB], 4'h0};
        REG_RANGE_PUMP: next_s.range_pump = {wb_in.dat[7:PUMP_LSB], 3'h0};
        REG_SYNC_CTRL: next_s.sync_ctrl = wb_in.dat[7:0];
        REG_COAST_CTRL: next_s.coast_ctrl = wb_in.dat[7:0];
        REG_SEP_TICKS: next_s.sep_ticks = wb_in.dat[7:0];
        REG_IRQ_MASK: next_s.irq_mask = wb_in.dat[3:0];
        default: next_s.div_high = s.div_high; // read-only, unmapped, or interrupt status (cleared below)
      endcase
    end
    // write one to clear; a new event in the same cycle wins
    next_s.irq_stat = s.irq_stat;
    if (wr && idx == REG_IRQ_STAT) begin
      next_s.irq_stat = s.irq_stat & ~wb_in.dat[3:0];
    end
    next_s.irq_stat = next_s.irq_stat | irq_ev;
  end

  // one register stage for all state
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
      s.div_high <= DIV_HIGH_RST;
      s.div_low <= DIV_LOW_RST;
      s.range_pump <= RANGE_PUMP_RST;
      s.sync_ctrl <= SYNC_CTRL_RST;
      s.coast_ctrl <= COAST_CTRL_RST;
      s.sep_ticks <= SEP_TICKS_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs; analog settings are decoded here for the oscillator
  assign wb_out.ack = s.ack;
  assign wb_out.dat = {24'h000000, s.rdata};
  assign vertical_sync_output_out = s.vout;
  assign irq_out = |(s.irq_stat & s.irq_mask);
  assign pll_out.ref_sel = s.hsel;
  assign pll_out.ref_pulse = s.ref_pulse;
  assign pll_out.coast = s.coast;
  assign pll_out.line_start = s.line;
  assign pll_out.ratio = {1'b0, div_val} + 13'h0001;
  assign pll_out.osc_range = s.range_pump[7:RANGE_LSB];
  assign pll_out.pump_sel = s.range_pump[RANGE_LSB-1:PUMP_LSB];
  assign pll_out.pump_ua = pps_pump_ua(s.range_pump[RANGE_LSB-1:PUMP_LSB]);

  // checks on selectors, line timing, bus and interrupt
  sequence bus_req_s;
    wb_in.cyc && wb_in.stb && !s.ack;
  endsequence

  sequence ack_pulse_s;
    s.ack ##1 !s.ack;
  endsequence

  vsrc_pin_wins_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!s.sync_ctrl[OV_V_BIT] && s.active[1]) |=> !s.vsel)
    else $error("vertical pin active but not selected");

  vsrc_green_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!s.sync_ctrl[OV_V_BIT] && !s.active[1] && s.active[2]) |=> s.vsel)
    else $error("green activity alone did not select separator");

  vsrc_manual_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (s.sync_ctrl[OV_V_BIT] || s.active[2:1] == 2'b00) |=> s.vsel == $past(s.sync_ctrl[MAN_V_BIT]))
    else $error("manual vertical source not followed");

  vout_source_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ##1 vertical_sync_output_out == ($past(s.vsel) ? $past(sep_v) : $past(s.level[PIN_V])))
    else $error("vertical output not from selected source");

  ratio_range_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pll_out.ratio >= 13'h0011 && pll_out.ratio <= 13'h1000)
    else $error("divider ratio out of range");

  ratio_sum_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    div_prog >= DIV_MIN |-> pll_out.ratio == {1'b0, div_prog} + 13'h0001)
    else $error("ratio is not programmed value plus one");

  coast_hold_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (s.coast && s.pix < div_val) |=> s.pix == $past(s.pix) + 12'h001 && !s.ref_pulse)
    else $error("line counter disturbed during coast");

  resync_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!s.coast && ref_edge) |=> s.ref_pulse && s.pix == 12'h000)
    else $error("reference edge did not realign after coast");

  line_wrap_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s.line |-> s.pix == 12'h000 && $past(s.pix) >= $past(div_val))
    else $error("line start not at the end of a full line");

  coast_source_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    ##1 s.coast == ($past(s.coast_ctrl[COAST_EXT_BIT]) ? $past(s.level[PIN_COAST]) : $past(s.vout)))
    else $error("coast not from selected source");

  bus_ack_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    bus_req_s |=> ack_pulse_s)
    else $error("ack not a single cycle after request");

  irq_level_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_out == |(s.irq_stat & s.irq_mask))
    else $error("interrupt output does not match masked status");

  // horizontal reference choice follows the activity flags
  hsrc_green_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!s.sync_ctrl[OV_H_BIT] && !s.active[0] && s.active[2]) |=> s.hsel)
    else $error("green sync alone did not become the reference");

  hsrc_pin_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (!s.sync_ctrl[OV_H_BIT] && !s.active[2]) |=> !s.hsel)
    else $error("horizontal pin not used without green activity");

  // status bits must sit where software looks for them
  status_map_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    status[STAT_HACT_BIT] == s.active[0] && status[STAT_VACT_BIT] == s.active[1]
      && status[STAT_GREEN_BIT] == s.active[2])
    else $error("status bits not at their places");

  // a divider write lands whole in the high half, only the top nibble in the low half
  sequence div_high_wr_s;
    wr && idx == REG_DIV_HIGH;
  endsequence

  sequence div_low_wr_s;
    wr && idx == REG_DIV_LOW;
  endsequence

  div_high_wr_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    div_high_wr_s |=> s.div_high == $past(wb_in.dat[7:0]))
    else $error("divider high half not written");

  div_low_wr_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    div_low_wr_s |=> s.div_low == {$past(wb_in.dat[7:DIV_LOW_LSB]), 4'h0})
    else $error("divider low half not written as its top nibble");

  // an event must land even when software clears the same bit in that cycle
  irq_set_wins_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    irq_ev != 4'h0 |=> (s.irq_stat & $past(irq_ev)) == $past(irq_ev))
    else $error("interrupt event lost");

  // no reference pulse without an accepted edge, and none during coast
  ref_cause_a:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    s.ref_pulse |-> $past(ref_edge) && !$past(s.coast))
    else $error("reference pulse without an edge or during coast");
endmodule
`default_nettype wire

// ===== pps_vid_src.sv
`timescale 1ns/1ns
`default_nettype none
module pps_vid_src (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic h_on_in,
  input wire logic v_on_in,
  input wire logic g_on_in,
  output logic h_out,
  output logic v_out,
  output logic g_out
);
  logic [6:0] cnt;
  // one frame of 96 cycles; pulses last at least 4 cycles so the pin filters see them
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 7'h00;
    end else begin
      cnt <= (cnt == 7'h5f) ? 7'h00 : cnt + 7'h01;
    end
  end
  // a source that is switched off parks its line low, as an idle sync line does
  assign h_out = h_on_in & (cnt[4:0] < 5'h04);
  assign v_out = v_on_in & (cnt < 7'h30);
  assign g_out = g_on_in & (cnt[3:0] < 4'h4);
endmodule
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pps_pkg::*;
  logic sys_clk_in, rst_in, coast_ext, h_on, v_on, g_on, h, v, g, vout, irq;
  pps_wb_req_t req;
  pps_wb_rsp_t rsp;
  pps_pll_ctl_t pll;
  logic [31:0] rnd = 32'hd94eca56;
  logic [7:0] expq[$];
  int ua[8] = '{50, 100, 150, 250, 350, 500, 750, 1500};
  int err_total = 0;
  int n_checks = 0;

  // short activity window keeps the run brief
  pps_top #(.ACT_WINDOW(64)) uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wb_in(req),
    .wb_out(rsp), .hsync_in(h), .vsync_in(v), .green_channel_sync_input_in(g),
    .coast_ext_in(coast_ext), .vertical_sync_output_out(vout), .pll_out(pll), .irq_out(irq));
  pps_vid_src src (.clk_in(sys_clk_in), .rst_in(rst_in), .h_on_in(h_on), .v_on_in(v_on),
    .g_on_in(g_on), .h_out(h), .v_out(v), .g_out(g));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  // classic cycle: hold everything until ack is sampled, then release for a cycle
  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {i, 2'b00}, sel: 4'h1, dat: {24'h0, d}};
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (rsp.ack !== 1'b1 && n < 40);
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (n >= 40) begin
      err_total++;
      give_verdict();
    end
    @(posedge sys_clk_in);
  endtask

  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    expq.push_back(e);
    wb(1'b0, i, 8'h00);
  endtask

  // bounded wait for the vertical pin to reach a level
  task automatic wait_v(input logic lv);
    int n;
    n = 0;
    while (v !== lv && n < 200) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      give_verdict();
    end
  endtask

  // vertical output must track the pin; 12 cycles covers synchroniser and register
  task automatic vfollow();
    // start on a fresh rising edge so the high phase outlasts the settle time
    wait_v(1'b0);
    wait_v(1'b1);
    tick(12);
    chk("vout_high", vout, 1);
    wait_v(1'b0);
    tick(12);
    chk("vout_low", vout, 0);
  endtask

  task automatic count_ref(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge sys_clk_in);
      c += (pll.ref_pulse === 1'b1);
    end
  endtask

  // read data watcher: every acked read takes the oldest expectation
  always @(posedge sys_clk_in) begin
    if (rsp.ack === 1'b1 && req.we === 1'b0) begin
      if (expq.size() == 0) begin
        chk("read_extra", 1, 0);
      end else begin
        chk("read_data", rsp.dat, {24'h0, expq.pop_front()});
      end
    end
  end

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    logic [11:0] d;
    int c;
    rst_in = 1'b1;
    req = '0;
    coast_ext = 1'b0;
    h_on = 1'b0;
    v_on = 1'b0;
    g_on = 1'b0;
    tick(5);
    rst_in <= 1'b0;
    tick(1);
    // reset values and an unmapped place
    chk("ratio_reset", pll.ratio, 1694);
    rd(REG_DIV_HIGH, 8'h69);
    rd(REG_DIV_LOW, 8'hd0);
    rd(REG_RANGE_PUMP, 8'h00);
    wb(1'b1, 6'h3f, 8'hff);
    rd(6'h3f, 8'h00);
    // divider: both ends, a clamped small value, then random settings
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      d = (k == 0) ? 12'hfff : (k == 1) ? 12'h010 : (k == 2) ? 12'h00f : rnd[11:0];
      wb(1'b1, REG_DIV_HIGH, d[11:4]);
      wb(1'b1, REG_DIV_LOW, {d[3:0], rnd[15:12]});
      chk("ratio", pll.ratio, (d < 12'h010) ? 17 : d + 1);
      rd(REG_DIV_LOW, {d[3:0], 4'h0});
    end
    // every range band and pump code; low bits are not stored
    for (int k = 0; k < 8; k++) begin
      wb(1'b1, REG_RANGE_PUMP, {k[1:0], k[2:0], 3'b111});
      chk("osc_range", pll.osc_range, k[1:0]);
      chk("pump_sel", pll.pump_sel, k[2:0]);
      chk("pump_ua", pll.pump_ua, ua[k]);
      rd(REG_RANGE_PUMP, {k[1:0], k[2:0], 3'b000});
    end
    // line length with divider 19, no reference present
    wb(1'b1, REG_DIV_HIGH, 8'h01);
    wb(1'b1, REG_DIV_LOW, 8'h30);
    c = 0;
    while (pll.line_start !== 1'b1 && c < 100) begin
      @(posedge sys_clk_in);
      c++;
    end
    if (c >= 100) begin
      err_total++;
      give_verdict();
    end
    c = 0;
    do begin
      @(posedge sys_clk_in);
      c++;
    end while (pll.line_start !== 1'b1 && c < 100);
    chk("line_len", c, 20);
    // vertical source: pin active wins with override clear and manual bit set, and is forced by override with manual bit clear
    v_on <= 1'b1;
    tick(200);
    rd(REG_STATUS, 8'h10);
    wb(1'b1, REG_STATUS, 8'h00);
    rd(REG_STATUS, 8'h10);
    wb(1'b1, REG_SYNC_CTRL, 8'h01);
    vfollow();
    wb(1'b1, REG_SYNC_CTRL, 8'h02);
    vfollow();
    // forced separator source: idle horizontal line keeps its output low
    wb(1'b1, REG_SYNC_CTRL, 8'h03);
    wait_v(1'b0);
    wait_v(1'b1);
    tick(12);
    chk("vout_sep", vout, 0);
    wb(1'b1, REG_SYNC_CTRL, 8'h00);
    vfollow();
    // green alone is taken as horizontal reference, then the horizontal pin alone
    v_on <= 1'b0;
    g_on <= 1'b1;
    tick(200);
    rd(REG_STATUS, 8'h02);
    chk("ref_sel_green", pll.ref_sel, 1);
    g_on <= 1'b0;
    h_on <= 1'b1;
    tick(200);
    rd(REG_STATUS, 8'h80);
    chk("ref_sel_pin", pll.ref_sel, 0);
    // coast from the external pin with its interrupt unmasked
    rd(REG_IRQ_STAT, 8'h0f);
    wb(1'b1, REG_IRQ_STAT, 8'h0f);
    rd(REG_IRQ_STAT, 8'h00);
    wb(1'b1, REG_IRQ_MASK, 8'h08);
    chk("irq_idle", irq, 0);
    wb(1'b1, REG_COAST_CTRL, 8'h20);
    coast_ext <= 1'b1;
    tick(10);
    chk("coast_on", pll.coast, 1);
    chk("irq_set", irq, 1);
    count_ref(100, c);
    chk("ref_in_coast", c, 0);
    coast_ext <= 1'b0;
    tick(10);
    chk("coast_off", pll.coast, 0);
    count_ref(100, c);
    chk("ref_resumed", c >= 3, 1);
    wb(1'b1, REG_IRQ_STAT, 8'h08);
    chk("irq_cleared", irq, 0);
    // masked event leaves the line low; internal source ignores the pin
    wb(1'b1, REG_IRQ_MASK, 8'h00);
    coast_ext <= 1'b1;
    tick(10);
    chk("irq_masked", irq, 0);
    wb(1'b1, REG_COAST_CTRL, 8'h00);
    tick(10);
    chk("coast_internal", pll.coast, 0);
    tick(5);
    chk("reads_left", expq.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
